// File: bench/ddt_core_model.sv
`timescale 1ns/1ps
// Stands in for the processor core that issues nibble writes to the timers.
module ddt_core_model (
  input  wire logic       mclk,
  output logic            regWrite,
  output logic [2:0]      regSel,
  output logic [3:0]      regData
);
  import ddt_pkg::*;
  initial begin
    regWrite = 1'b0;
    regSel = 3'h7;
    regData = 4'h0;
  end
  // Launch on a falling edge and hold through the taking rising edge.
  task automatic wr(input logic [2:0] s, input logic [3:0] d);
    @(negedge mclk);
    regWrite = 1'b1;
    regSel = s;
    regData = d;
    @(negedge mclk);
    regWrite = 1'b0;
    // Released data shows the inverse, so a stale nibble is never trusted.
    regData = ~d;
  endtask : wr
endmodule : ddt_core_model

// File: bench/ddt_dual_down_timer_tb.sv
`timescale 1ns/1ps
module ddt_dual_down_timer_tb;
  import ddt_pkg::*;
  logic       mclk, sys_rst, regWrite, subOscTick, waveGenOut, p;
  logic       intEnable1, intEnable7, holdEnable1, holdEnable7, evtClear1, evtClear7;
  logic       eventFlag1, eventFlag7, intRequest, holdRelease, mfPin;
  logic [2:0] regSel;
  logic [3:0] regData;
  logic [7:0] firstCount, reloadCount, snap;
  int         nFail = 0, totalChecks = 0, n = 0, k = 0;
  ddt_core_model core (.mclk(mclk), .regWrite(regWrite), .regSel(regSel), .regData(regData));
  ddt_dual_down_timer DUT (
    .mclk(mclk), .sys_rst(sys_rst), .regWrite(regWrite), .regSel(regSel), .regData(regData),
    .evtClear1(evtClear1), .evtClear7(evtClear7), .intEnable1(intEnable1),
    .intEnable7(intEnable7),
    .holdEnable1(holdEnable1), .holdEnable7(holdEnable7), .subOscTick(subOscTick),
    .waveGenOut(waveGenOut), .eventFlag1(eventFlag1), .eventFlag7(eventFlag7),
    .intRequest(intRequest), .holdRelease(holdRelease), .multiFunctionOutputPin(mfPin),
    .firstCount(firstCount), .reloadCount(reloadCount));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Sub-oscillator enable every 16 cycles, so its rate is told apart from the others.
  always @(negedge mclk) begin
    k <= k + 1;
    subOscTick <= (k % 16 == 0);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait, so a timer that never underflows cannot hang the run.
  task automatic waitf(input bit sev, output int c);
    c = 0;
    while (((sev ? eventFlag7 : eventFlag1) !== 1'b1) && c < 3000) begin
      @(negedge mclk);
      c++;
    end
  endtask : waitf
  task automatic cyc(input int m);
    repeat (m) @(negedge mclk);
  endtask : cyc
  task automatic completeRun;
    $display("checks=%0d mismatches=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : completeRun
  initial begin
    #(40 * 12000);
    nFail++;
    completeRun();
  end
  // Each prescaler restarts with its timer, so internal-clock intervals are exact.
  initial begin
    {sys_rst, waveGenOut, intEnable1, intEnable7, holdEnable1, holdEnable7} = 6'h20;
    {evtClear1, evtClear7} = 2'h0;
    cyc(5);
    sys_rst = 1'b0;
    cyc(1);
    chk({5'h0, eventFlag1, eventFlag7, mfPin}, 8'h00);
    chk(firstCount | reloadCount, COUNT_RESET);
    core.wr(REG_T0_PRESET_HI, 4'h0);
    core.wr(REG_T0_PRESET_LO, 4'h5);
    chk(firstCount, 8'h05);
    core.wr(REG_T0_MODE, 4'h8);
    waitf(1'b0, n);
    chk(8'(n), 8'h18);
    cyc(12);
    chk({firstCount[3:0], 3'h0, eventFlag1}, 8'hF1);
    intEnable1 = 1'b1;
    cyc(1);
    chk({6'h0, intRequest, holdRelease}, 8'h02);
    intEnable1 = 1'b0;
    holdEnable1 = 1'b1;
    cyc(1);
    chk({6'h0, intRequest, holdRelease}, 8'h01);
    core.wr(REG_T0_MODE, 4'h8);
    chk({7'h0, eventFlag1}, 8'h00);
    cyc(3);
    core.wr(REG_T0_PRESET_HI, 4'h0);
    core.wr(REG_T0_PRESET_LO, 4'h3);
    cyc(8);
    chk(firstCount, 8'h03);
    core.wr(REG_T0_PRESET_LO, 4'h1);
    core.wr(REG_T0_MODE, 4'hF);
    waitf(1'b0, n);
    chk(8'(n == 2048), 8'h01);
    evtClear1 = 1'b1;
    cyc(1);
    evtClear1 = 1'b0;
    chk({7'h0, eventFlag1}, 8'h00);
    $display("one-shot timer test done");
    core.wr(REG_T1_PRESET_HI, 4'h0);
    core.wr(REG_T1_PRESET_LO, 4'h3);
    core.wr(REG_T1_MODE, 4'hC);
    chk({7'h0, eventFlag7}, 8'h00);
    n = 0;
    repeat (40) begin
      p = mfPin;
      @(negedge mclk);
      if (mfPin !== p) n++;
    end
    chk(8'(n), 8'h0A);
    chk({7'h0, eventFlag7}, 8'h01);
    evtClear7 = 1'b1;
    cyc(4);
    chk({7'h0, eventFlag7}, 8'h01);
    cyc(1);
    evtClear7 = 1'b0;
    chk({7'h0, eventFlag7}, 8'h00);
    cyc(3);
    {intEnable7, holdEnable7, holdEnable1} = 3'h6;
    cyc(1);
    chk({6'h0, intRequest, holdRelease}, 8'h03);
    core.wr(REG_T1_PRESET_LO, 4'h1);
    snap = reloadCount;
    cyc(8);
    chk(reloadCount, snap);
    $display("reload timer tone test done");
    core.wr(REG_T1_MODE, 4'h0);
    waveGenOut = 1'b1;
    cyc(1);
    chk({7'h0, mfPin}, 8'h01);
    core.wr(REG_T1_MODE, 4'h9);
    waitf(1'b1, n);
    chk(8'(n), 8'h80);
    core.wr(REG_T1_MODE, 4'hA);
    waitf(1'b1, n);
    chk(8'(n >= 16 && n <= 33), 8'h01);
    $display("reload timer clock source test done");
    completeRun();
  end
endmodule : ddt_dual_down_timer_tb

// File: design/ddt_dual_down_timer.sv
`timescale 1ns/1ps
module ddt_dual_down_timer (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 regWrite,
  input  wire logic [2:0]           regSel,
  input  wire logic [3:0]           regData,
  input  wire logic                 evtClear1,
  input  wire logic                 evtClear7,
  input  wire logic                 intEnable1,
  input  wire logic                 intEnable7,
  input  wire logic                 holdEnable1,
  input  wire logic                 holdEnable7,
  input  wire logic                 subOscTick,
  input  wire logic                 waveGenOut,
  output logic                      eventFlag1,
  output logic                      eventFlag7,
  output logic                      intRequest,
  output logic                      holdRelease,
  output logic                      multiFunctionOutputPin,
  output logic [7:0]                firstCount,
  output logic [7:0]                reloadCount
);
  import ddt_pkg::*;

  // Width of the second timer's own divide-by-64 stage.
  localparam int T1_PRE_W = $clog2(T1_DIV_SLOW);

  typedef struct packed {
    logic [PRE_WIDTH-1:0] pre0;
    logic [T1_PRE_W-1:0]  pre1;
    logic [7:0]           cnt0;
    logic [3:0]           mode0;
    logic                 evf1;
    logic [7:0]           buf1;
    logic [7:0]           cnt1;
    logic [3:0]           mode1;
    logic                 evf7;
    logic                 tone;
  } ddt_state_s;

  ddt_state_s st_q;
  ddt_state_s st_d;

  logic tick0;
  logic tick1;
  logic wr0Lo;
  logic wr0Hi;
  logic wr0Mode;
  logic wr1Lo;
  logic wr1Hi;
  logic wr1Mode;
  logic under0;
  logic under1;

  // Decode of a write to one register select.
  function automatic logic selHit(input logic w, input logic [2:0] s, input logic [2:0] r);
    return w && (s == r);
  endfunction : selHit

  // True when a prescaler count has reached the last state of its period.
  function automatic logic preDone(input logic [PRE_WIDTH-1:0] c, input int div);
    return c == PRE_WIDTH'(div - 1);
  endfunction : preDone

  assign wr0Lo   = selHit(regWrite, regSel, REG_T0_PRESET_LO);
  assign wr0Hi   = selHit(regWrite, regSel, REG_T0_PRESET_HI);
  assign wr0Mode = selHit(regWrite, regSel, REG_T0_MODE);
  assign wr1Lo   = selHit(regWrite, regSel, REG_T1_PRESET_LO);
  assign wr1Hi   = selHit(regWrite, regSel, REG_T1_PRESET_HI);
  assign wr1Mode = selHit(regWrite, regSel, REG_T1_MODE);

  // Each timer owns its prescaler, cleared on every start; only the first timer's is also cleared on a preset write.
  // A shared free-running divider would save flops but let the first tick come early,
  // which would cut the interval below (preset+1) times the prescale factor.
  always_comb begin
    tick0 = 1'b0;
    tick1 = 1'b0;
    if (st_q.mode0[MODE_RUN_BIT]) begin
      if (st_q.mode0[MODE_PRESCALE_BIT]) begin
        tick0 = preDone(st_q.pre0, T0_DIV_SLOW);
      end else begin
        tick0 = preDone(st_q.pre0, T0_DIV_FAST);
      end
    end
    if (st_q.mode1[MODE_SUBOSC_BIT]) begin
      tick1 = subOscTick;
    end else if (st_q.mode1[MODE_PRESCALE_BIT]) begin
      tick1 = (st_q.pre1 == T1_PRE_W'(T1_DIV_SLOW - 1));
    end else begin
      tick1 = 1'b1;
    end
  end

  assign under0 = st_q.mode0[MODE_RUN_BIT] && tick0 && (st_q.cnt0 == COUNT_RESET);
  assign under1 = st_q.mode1[MODE_RUN_BIT] && tick1 && (st_q.cnt1 == COUNT_RESET);

  // Next-state logic for both timers.
  always_comb begin
    st_d = st_q;
    // Prescalers advance only while their timer runs and wrap on their own tick.
    if (st_q.mode0[MODE_RUN_BIT]) begin
      st_d.pre0 = tick0 ? '0 : st_q.pre0 + PRE_WIDTH'(1);
    end
    if (st_q.mode1[MODE_RUN_BIT] && !st_q.mode1[MODE_SUBOSC_BIT]) begin
      st_d.pre1 = tick1 ? '0 : st_q.pre1 + T1_PRE_W'(1);
    end
    // Flag clears lose to a same-cycle underflow so no event is dropped.
    if (evtClear1) begin
      st_d.evf1 = 1'b0;
    end
    if (evtClear7) begin
      st_d.evf7 = 1'b0;
    end
    // First timer.
    if (wr0Lo || wr0Hi) begin
      st_d.mode0[MODE_RUN_BIT] = 1'b0;
      st_d.pre0 = '0;
      if (wr0Lo) begin
        st_d.cnt0[3:0] = regData;
      end else begin
        st_d.cnt0[7:4] = regData;
      end
    end else if (wr0Mode) begin
      st_d.mode0 = {regData[MODE_RUN_BIT], 2'b00, regData[MODE_PRESCALE_BIT]};
      st_d.pre0 = '0;
      if (regData[MODE_RUN_BIT]) begin
        st_d.evf1 = 1'b0;
      end
    end else if (st_q.mode0[MODE_RUN_BIT] && tick0) begin
      st_d.cnt0 = st_q.cnt0 - 8'h01;
      if (under0) begin
        st_d.mode0[MODE_RUN_BIT] = 1'b0;
        st_d.evf1 = 1'b1;
      end
    end
    // Second timer.
    if (wr1Lo || wr1Hi) begin
      st_d.mode1[MODE_RUN_BIT] = 1'b0;
      if (wr1Lo) begin
        st_d.buf1[3:0] = regData;
      end else begin
        st_d.buf1[7:4] = regData;
      end
    end else if (wr1Mode) begin
      st_d.mode1 = regData;
      st_d.pre1 = '0;
      if (regData[MODE_RUN_BIT]) begin
        st_d.cnt1 = st_q.buf1;
        st_d.evf7 = 1'b0;
      end
    end else if (st_q.mode1[MODE_RUN_BIT] && tick1) begin
      if (under1) begin
        st_d.cnt1 = st_q.buf1;
        st_d.evf7 = 1'b1;
        st_d.tone = ~st_q.tone;
      end else begin
        st_d.cnt1 = st_q.cnt1 - 8'h01;
      end
    end
  end

  // Single state register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.mode0 <= MODE_RESET;
      st_q.mode1 <= MODE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs; the enables are masks owned by the interrupt controller.
  assign eventFlag1  = st_q.evf1;
  assign eventFlag7  = st_q.evf7;
  assign intRequest  = (st_q.evf1 && intEnable1) || (st_q.evf7 && intEnable7);
  assign holdRelease = (st_q.evf1 && holdEnable1) || (st_q.evf7 && holdEnable7);
  assign multiFunctionOutputPin = st_q.mode1[MODE_TONE_BIT] ? st_q.tone : waveGenOut;
  assign firstCount  = st_q.cnt0;
  assign reloadCount = st_q.cnt1;

  // Assertions.
  sequence t0Load_s;
    wr0Lo || wr0Hi;
  endsequence
  sequence t1Load_s;
    wr1Lo || wr1Hi;
  endsequence

  preset_halts_a: assert property (@(posedge mclk) disable iff (sys_rst)
    t0Load_s |=> !st_q.mode0[MODE_RUN_BIT]) else $error("first timer ran after preset write");
  start_clr_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr0Mode && regData[MODE_RUN_BIT] && !evtClear1 |=> !eventFlag1 && st_q.mode0[MODE_RUN_BIT])
    else $error("first start did not clear flag");
  oneshot_stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    under0 && !regWrite |=> eventFlag1 && !st_q.mode0[MODE_RUN_BIT] && firstCount == COUNT_UNDER)
    else $error("first underflow wrong");
  irq_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    eventFlag1 && intEnable1 |-> intRequest) else $error("missing interrupt");
  mode0_reserved_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode0[2:1] == 2'b00) else $error("reserved mode bits set");
  reload_halt_a: assert property (@(posedge mclk) disable iff (sys_rst)
    t1Load_s |=> !st_q.mode1[MODE_RUN_BIT] && reloadCount == $past(reloadCount))
    else $error("reload preset write wrong");
  start_reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr1Mode && regData[MODE_RUN_BIT] |=> reloadCount == $past(st_q.buf1))
    else $error("second start did not load buffer");
  auto_reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
    under1 && !regWrite |=> eventFlag7 && st_q.mode1[MODE_RUN_BIT] && reloadCount == st_q.buf1)
    else $error("second underflow wrong");
  tone_route_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_q.mode1[MODE_TONE_BIT] |-> multiFunctionOutputPin == waveGenOut)
    else $error("pin routing wrong");
  stop_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_q.mode0[MODE_RUN_BIT] && !regWrite ##1 !regWrite |-> $stable(firstCount))
    else $error("stopped count moved");

  // Nibble loads land in the half of the first counter or reload buffer that their select names.
  preset_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr0Lo |=> firstCount[3:0] == $past(regData)) else $error("low preset nibble lost");
  preset_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr0Hi |=> firstCount[7:4] == $past(regData)) else $error("high preset nibble lost");
  reload_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr1Lo |=> st_q.buf1[3:0] == $past(regData)) else $error("reload low nibble lost");
  reload_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr1Hi |=> st_q.buf1[7:4] == $past(regData)) else $error("reload high nibble lost");

  // Starting and stopping through the mode registers.
  start_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr0Mode && regData[MODE_RUN_BIT] |=> firstCount == $past(firstCount))
    else $error("first start changed the count");
  mode_stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr0Mode && !regData[MODE_RUN_BIT] |=> !st_q.mode0[MODE_RUN_BIT])
    else $error("first timer did not stop");
  prescale_pick_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr0Mode |=> st_q.mode0[MODE_PRESCALE_BIT] == $past(regData[MODE_PRESCALE_BIT]))
    else $error("first prescale not stored");
  second_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr1Mode && regData[MODE_RUN_BIT] |=> !eventFlag7 && st_q.mode1[MODE_RUN_BIT])
    else $error("second start did not clear flag");

  // The divide-by-4 stage ticks on every fourth cycle of an undisturbed run.
  sequence t0FastTick_s;
    tick0 && !st_q.mode0[MODE_PRESCALE_BIT];
  endsequence
  sequence t0Quiet_s;
    st_q.mode0[MODE_RUN_BIT] && !regWrite;
  endsequence
  fast_gap_a: assert property (@(posedge mclk) disable iff (sys_rst)
    t0FastTick_s |=> !tick0 [*3]) else $error("first prescale ticked early");
  fast_period_a: assert property (@(posedge mclk) disable iff (sys_rst)
    t0FastTick_s ##1 t0Quiet_s [*4] |-> tick0) else $error("first prescale ticked late");

  // Second timer pacing and its clock sources.
  direct_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode1[MODE_RUN_BIT] && !st_q.mode1[MODE_SUBOSC_BIT] &&
    !st_q.mode1[MODE_PRESCALE_BIT] && !regWrite && !under1
    |=> reloadCount == $past(reloadCount) - 8'h01) else $error("second timer missed a step");
  sub_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode1[MODE_SUBOSC_BIT] && !subOscTick && !regWrite |=> $stable(reloadCount))
    else $error("second timer moved without a sub-oscillator tick");
  div_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode1[MODE_PRESCALE_BIT] && !st_q.mode1[MODE_SUBOSC_BIT] && !tick1 && !regWrite
    |=> $stable(reloadCount)) else $error("second timer moved between divided ticks");
  second_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_q.mode1[MODE_RUN_BIT] && !regWrite && !evtClear7
    |=> $stable(reloadCount) && $stable(eventFlag7)) else $error("stopped reload timer moved");

  // A clear that meets an underflow in the same cycle loses, so no event is dropped.
  t0_set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
    under0 && evtClear1 && !regWrite |=> eventFlag1) else $error("first event lost to clear");
  t1_set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
    under1 && evtClear7 && !regWrite |=> eventFlag7) else $error("second event lost to clear");
  flag_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    evtClear1 && !under0 |=> !eventFlag1) else $error("first event flag not cleared");

  // Interrupt and hold-release requests follow flags and masks exactly.
  irq_second_a: assert property (@(posedge mclk) disable iff (sys_rst)
    eventFlag7 && intEnable7 |-> intRequest) else $error("missing second interrupt");
  hold_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
    eventFlag1 && holdEnable1 |-> holdRelease) else $error("missing first hold release");
  hold_second_a: assert property (@(posedge mclk) disable iff (sys_rst)
    eventFlag7 && holdEnable7 |-> holdRelease) else $error("missing second hold release");
  irq_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(eventFlag1 && intEnable1) && !(eventFlag7 && intEnable7) |-> !intRequest)
    else $error("spurious interrupt");
  hold_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(eventFlag1 && holdEnable1) && !(eventFlag7 && holdEnable7) |-> !holdRelease)
    else $error("spurious hold release");

  // The tone pin flips once per underflow and nowhere else.
  tone_flip_a: assert property (@(posedge mclk) disable iff (sys_rst)
    under1 && st_q.mode1[MODE_TONE_BIT] && !regWrite
    |=> multiFunctionOutputPin != $past(multiFunctionOutputPin))
    else $error("tone missed a flip");
  tone_steady_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode1[MODE_TONE_BIT] && !under1 && !regWrite |=> $stable(multiFunctionOutputPin))
    else $error("tone flipped without an underflow");
  tone_select_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode1[MODE_TONE_BIT] |-> multiFunctionOutputPin == st_q.tone)
    else $error("tone not routed to pin");

  // Counting steps and held values.
  first_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_q.mode0[MODE_RUN_BIT] && !regWrite && !evtClear1 |=> $stable(eventFlag1))
    else $error("stopped first timer changed its flag");
  buffer_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !wr1Lo && !wr1Hi |=> $stable(st_q.buf1))
    else $error("reload buffer changed without a preset write");
  first_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick0 && !under0 && !regWrite |=> firstCount == $past(firstCount) - 8'h01)
    else $error("first tick did not step the count");
  div_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q.mode1[MODE_PRESCALE_BIT] && !st_q.mode1[MODE_SUBOSC_BIT] && tick1 && !under1
    && st_q.mode1[MODE_RUN_BIT] && !regWrite |=> reloadCount == $past(reloadCount) - 8'h01)
    else $error("divided tick did not step the second timer");
  tick_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_q.mode0[MODE_RUN_BIT] |-> !tick0) else $error("stopped first timer ticked");

  // Reset leaves both timers stopped on the fast prescale and direct clock.
  reset_stop_a: assert property (@(posedge mclk)
    sys_rst |=> st_q.mode0 == MODE_RESET && st_q.mode1 == MODE_RESET && !eventFlag1)
    else $error("reset left a timer armed");
endmodule : ddt_dual_down_timer

// File: design/ddt_pkg.sv
package ddt_pkg;
  // Register selects for the processor core's nibble writes.
  localparam logic [2:0] REG_T0_PRESET_LO = 3'h0;
  localparam logic [2:0] REG_T0_PRESET_HI = 3'h1;
  localparam logic [2:0] REG_T0_MODE      = 3'h2;
  localparam logic [2:0] REG_T1_PRESET_LO = 3'h3;
  localparam logic [2:0] REG_T1_PRESET_HI = 3'h4;
  localparam logic [2:0] REG_T1_MODE      = 3'h5;

  // Mode register field positions.
  localparam int MODE_PRESCALE_BIT = 0;
  localparam int MODE_SUBOSC_BIT   = 1;
  localparam int MODE_TONE_BIT     = 2;
  localparam int MODE_RUN_BIT      = 3;

  // Prescale factors.
  localparam int T0_DIV_FAST = 4;
  localparam int T0_DIV_SLOW = 1024;
  localparam int T1_DIV_SLOW = 64;
  localparam int PRE_WIDTH   = 10;

  // Reset values and the count left by an underflow.
  localparam logic [3:0] MODE_RESET  = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_UNDER = 8'hFF;

  // Event flag bit positions shared with enable masks.
  localparam int EVT_T0_BIT = 1;
  localparam int EVT_T1_BIT = 7;
endpackage : ddt_pkg
